// ---- hdl/emp_cfg.svh ----
// Register indices, field positions and reset values of the external memory port.
`ifndef EMP_CFG_SVH
`define EMP_CFG_SVH

// Register indices; the Wishbone byte address is four times the index.
`define EMP_IDX_P4_MODE 8'h9c
`define EMP_IDX_TIMING 8'ha1
`define EMP_IDX_PAGE 8'ha2
`define EMP_IDX_CONFIG 8'ha3
`define EMP_IDX_P4_DATA 8'hc8

// Reset values.
`define EMP_RST_P4_MODE 8'h00
`define EMP_RST_TIMING 8'hff
`define EMP_RST_PAGE 8'h00
`define EMP_RST_CONFIG 8'h00
`define EMP_RST_P4_DATA 8'hff

// Timing register fields.
`define EMP_TC_SETUP_HI 7
`define EMP_TC_SETUP_LO 6
`define EMP_TC_WIDTH_HI 5
`define EMP_TC_WIDTH_LO 2
`define EMP_TC_HOLD_HI 1
`define EMP_TC_HOLD_LO 0

// Configuration register fields.
`define EMP_CF_UPPER_BIT 5
`define EMP_CF_MUX_BIT 4
`define EMP_CF_MODE_HI 1
`define EMP_CF_MODE_LO 0

// Port four pins that carry the strobes on the upper group.
`define EMP_P4_WR_BIT 7
`define EMP_P4_RD_BIT 6
`define EMP_P4_ALE_BIT 5

// Default size of on-chip data memory in split modes.
`define EMP_ONCHIP_BYTES 8192

`endif

// ---- hdl/emp_pkg.sv ----
// Types shared by the external memory port design.
`default_nettype none
package emp_pkg;

   // Sequencer states, one-hot.
   typedef enum logic [5:0] {
      EMP_IDLE   = 6'b000001,
      EMP_ALE    = 6'b000010,
      EMP_SETUP  = 6'b000100,
      EMP_STROBE = 6'b001000,
      EMP_HOLD   = 6'b010000,
      EMP_DONE   = 6'b100000
   } emp_state_t;

   // Memory modes held in the configuration register.
   typedef enum logic [1:0] {
      EMP_MODE_ONCHIP  = 2'h0,
      EMP_MODE_SPLIT   = 2'h1,
      EMP_MODE_BANKED  = 2'h2,
      EMP_MODE_OFFCHIP = 2'h3
   } emp_mode_t;

endpackage : emp_pkg
`default_nettype wire

// ---- hdl/emp_sync.sv ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`default_nettype none
module emp_sync #(
   parameter int W = 8
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Raw pins and filtered result.
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
);

   logic [W-1:0] s1; // First stage, read only by the second stage.
   logic [W-1:0] s2; // Second stage.
   logic [W-1:0] s3; // Third stage.

   generate
      if (W < 1)
      begin : g_bad
         $error("emp_sync width must be at least one");
      end
   endgenerate

   // Shift the pins through three flops; the first stage may be metastable.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end
      else
      begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Each bit takes a new level only when two settled stages agree.
   genvar b;
   generate
      for (b = 0; b < W; b = b + 1)
      begin : g_bit
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
               level_o[b] <= 1'b0;
            else if (s2[b] == s3[b])
               level_o[b] <= s3[b];
         end
      end
   endgenerate

endmodule // emp_sync
`default_nettype wire

// ---- hdl/emp_top.sv ----
// External data memory port: register file, access sequencer and pin steering.
//
// Decided for this implementation: the Wishbone interface to the registers.
`include "emp_cfg.svh"
`default_nettype none
// Operation
// - Steer interface to lower or upper port group.
// - Claim pins only during off-chip moves.
// - Disable drivers of pins acting as inputs.
// - Output mode stays under mode registers.
// - Page byte is high address for short moves.
// - Setup field gives zero to three cycles.
// - Strobe low lasts width field plus one.
// - Hold field gives zero to three cycles.
// - Port four writes drive pins low/high.
// - Port four reads return actual pin levels.
// - Upper group uses port four top strobes.
// - Port four mode bit: open-drain or push-pull.
// - Four memory modes chosen by software.
// - Group, multiplex and mode in config register.
module emp_top #(
   parameter int ONCHIP_BYTES = `EMP_ONCHIP_BYTES
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Wishbone classic slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Core external data move request.
   input wire logic mv_req_i,
   input wire logic mv_we_i,
   input wire logic mv_short_i,
   input wire logic [15:0] mv_addr_i,
   input wire logic [7:0] mv_wdata_i,
   output logic mv_busy_o,
   output logic mv_done_o,
   output logic [7:0] mv_rdata_o,
   // Lower port group pins.
   output logic lo_claim_o,
   output logic [15:0] lo_addr_o,
   output logic lo_addr_hi_oe_o,
   output logic lo_addr_lo_oe_o,
   output logic [7:0] lo_data_o,
   output logic lo_data_oe_o,
   input wire logic [7:0] lo_data_i,
   output logic lo_wr_n_o,
   output logic lo_rd_n_o,
   output logic lo_ale_o,
   // Upper port group pins.
   output logic hi_claim_o,
   output logic [15:0] hi_addr_o,
   output logic hi_addr_hi_oe_o,
   output logic hi_addr_lo_oe_o,
   output logic [7:0] hi_data_o,
   output logic hi_data_oe_o,
   input wire logic [7:0] hi_data_i,
   // Port four pins.
   output logic [7:0] port4_o,
   output logic [7:0] port4_oe_o,
   input wire logic [7:0] port4_i
);

   generate
      if (ONCHIP_BYTES < 1 || ONCHIP_BYTES > 65536)
      begin : g_bad
         $error("ONCHIP_BYTES must lie between 1 and 65536");
      end
   endgenerate

   localparam logic [16:0] ONCHIP_TOP = 17'(ONCHIP_BYTES); // First off-chip address.

   logic rst_q1; // Reset release, first stage.
   logic rst_n; // Reset used by the design.

   // Release reset through two flops so every flop leaves reset on the same edge.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   // Software-visible registers.
   logic [7:0] port4_output_mode; // Per-pin drive mode of port four.
   logic [7:0] external_timing_control; // Setup, width and hold fields.
   logic [7:0] external_page_select; // High address byte for short moves.
   logic [7:0] interface_config_reg; // Group, multiplex and memory mode.
   logic [7:0] port4_data_latch; // Port four output latch.

   // Synchronised pin levels.
   logic [7:0] lo_data_s;
   logic [7:0] hi_data_s;
   logic [7:0] port4_s;

   emp_sync #(.W(8)) u_sync_lo (.clk_i(clk_i), .rst_n_i(rst_n), .pin_i(lo_data_i),
      .level_o(lo_data_s));
   emp_sync #(.W(8)) u_sync_hi (.clk_i(clk_i), .rst_n_i(rst_n), .pin_i(hi_data_i),
      .level_o(hi_data_s));
   emp_sync #(.W(8)) u_sync_p4 (.clk_i(clk_i), .rst_n_i(rst_n), .pin_i(port4_i),
      .level_o(port4_s));

   // Register decode.
   wire [7:0] reg_idx = wb_adr_i[9:2];
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
   wire hit_mode = (reg_idx == `EMP_IDX_P4_MODE);
   wire hit_timing = (reg_idx == `EMP_IDX_TIMING);
   wire hit_page = (reg_idx == `EMP_IDX_PAGE);
   wire hit_config = (reg_idx == `EMP_IDX_CONFIG);
   wire hit_data = (reg_idx == `EMP_IDX_P4_DATA);

   // Read mux; port four reads the pins, not the latch, and unmapped reads give zero.
   wire [7:0] rd_byte =
      hit_mode ? port4_output_mode :
      hit_timing ? external_timing_control :
      hit_page ? external_page_select :
      hit_config ? interface_config_reg :
      hit_data ? port4_s : 8'h00;

   // Register file writes; byte lane zero carries every register.
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         port4_output_mode <= `EMP_RST_P4_MODE;
         external_timing_control <= `EMP_RST_TIMING;
         external_page_select <= `EMP_RST_PAGE;
         interface_config_reg <= `EMP_RST_CONFIG;
         port4_data_latch <= `EMP_RST_P4_DATA;
      end
      else if (bus_wr)
      begin
         if (hit_mode)
            port4_output_mode <= wb_dat_i[7:0];
         if (hit_timing)
            external_timing_control <= wb_dat_i[7:0];
         if (hit_page)
            external_page_select <= wb_dat_i[7:0];
         if (hit_config)
            interface_config_reg <= wb_dat_i[7:0];
         if (hit_data)
            port4_data_latch <= wb_dat_i[7:0];
      end
   end

   // Answer every strobe one cycle later, mapped or not, and drop ack after one cycle.
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= bus_req;
         if (bus_req)
            wb_dat_o <= {24'h00_0000, rd_byte};
      end
   end

   // Configuration fields.
   wire upper_port_select = interface_config_reg[`EMP_CF_UPPER_BIT];
   wire mux_mode = interface_config_reg[`EMP_CF_MUX_BIT];
   wire [1:0] mode_bits = interface_config_reg[`EMP_CF_MODE_HI:`EMP_CF_MODE_LO];
   wire [1:0] addr_setup_field =
      external_timing_control[`EMP_TC_SETUP_HI:`EMP_TC_SETUP_LO];
   wire [3:0] strobe_width_field =
      external_timing_control[`EMP_TC_WIDTH_HI:`EMP_TC_WIDTH_LO];
   wire [1:0] addr_hold_field =
      external_timing_control[`EMP_TC_HOLD_HI:`EMP_TC_HOLD_LO];

   // Full move address; short moves take the page byte as the high byte.
   wire [15:0] move_addr = mv_short_i ? {external_page_select, mv_addr_i[7:0]} :
      mv_addr_i;
   wire above_onchip = ({1'b0, move_addr} >= ONCHIP_TOP);

   // Off-chip decision per memory mode.
   wire go_offchip =
      (mode_bits == emp_pkg::EMP_MODE_OFFCHIP) ? 1'b1 :
      (mode_bits == emp_pkg::EMP_MODE_ONCHIP) ? 1'b0 : above_onchip;

   // Without bank select a short move leaves the high address pins to the latches.
   wire drive_high = ~(mv_short_i & (mode_bits == emp_pkg::EMP_MODE_SPLIT));

   // Sequencer state and pin-facing registers.
   emp_pkg::emp_state_t state;
   logic [3:0] cnt; // Cycles left in the current phase, minus one.
   logic mv_we; // Direction of the move in progress.
   logic claim; // Interface owns its pins.
   logic [15:0] ext_addr; // Address on the pins.
   logic addr_hi_oe; // High address byte driven.
   logic addr_lo_oe; // Low address byte driven.
   logic [7:0] ext_dout; // Data bus output.
   logic ext_doe; // Data bus driven.
   logic wr_n; // Write strobe, active low.
   logic rd_n; // Read strobe, active low.
   logic ale; // Address latch strobe.
   logic [7:0] ext_din; // Synchronised data of the selected group.

   assign ext_din = upper_port_select ? hi_data_s : lo_data_s;

   // Width field loads the strobe counter.
   wire [3:0] width_cnt = strobe_width_field;

   // The sequencer: ALE, setup, strobe, hold, done; a new move waits in idle.
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= emp_pkg::EMP_IDLE;
         cnt <= 4'h0;
         mv_we <= 1'b0;
         claim <= 1'b0;
         ext_addr <= 16'h0000;
         addr_hi_oe <= 1'b0;
         addr_lo_oe <= 1'b0;
         ext_dout <= 8'h00;
         ext_doe <= 1'b0;
         wr_n <= 1'b1;
         rd_n <= 1'b1;
         ale <= 1'b0;
         mv_done_o <= 1'b0;
         mv_rdata_o <= 8'h00;
      end
      else
      begin
         mv_done_o <= 1'b0;
         unique case (state)
            emp_pkg::EMP_IDLE:
            begin
               if (mv_req_i && !go_offchip)
               begin
                  // On-chip moves are served elsewhere; pins stay untouched.
                  state <= emp_pkg::EMP_DONE;
                  mv_done_o <= 1'b1;
               end
               else if (mv_req_i)
               begin
                  claim <= 1'b1;
                  mv_we <= mv_we_i;
                  ext_addr <= move_addr;
                  addr_hi_oe <= drive_high;
                  addr_lo_oe <= ~mux_mode;
                  ext_dout <= mux_mode ? move_addr[7:0] : mv_wdata_i;
                  ext_doe <= mux_mode;
                  if (mux_mode)
                  begin
                     // Low address shares the data bus and is latched by ALE.
                     ale <= 1'b1;
                     state <= emp_pkg::EMP_ALE;
                  end
                  else if (addr_setup_field != 2'h0)
                  begin
                     cnt <= {2'h0, addr_setup_field} - 4'h1;
                     state <= emp_pkg::EMP_SETUP;
                  end
                  else
                  begin
                     cnt <= width_cnt;
                     wr_n <= ~mv_we_i;
                     rd_n <= mv_we_i;
                     ext_dout <= mv_wdata_i;
                     ext_doe <= mv_we_i;
                     state <= emp_pkg::EMP_STROBE;
                  end
               end
            end
            emp_pkg::EMP_ALE:
            begin
               ale <= 1'b0;
               if (addr_setup_field != 2'h0)
               begin
                  cnt <= {2'h0, addr_setup_field} - 4'h1;
                  state <= emp_pkg::EMP_SETUP;
               end
               else
               begin
                  cnt <= width_cnt;
                  wr_n <= ~mv_we;
                  rd_n <= mv_we;
                  ext_dout <= mv_wdata_i;
                  ext_doe <= mv_we;
                  state <= emp_pkg::EMP_STROBE;
               end
            end
            emp_pkg::EMP_SETUP:
            begin
               if (cnt == 4'h0)
               begin
                  cnt <= width_cnt;
                  wr_n <= ~mv_we;
                  rd_n <= mv_we;
                  ext_dout <= mv_wdata_i;
                  ext_doe <= mv_we;
                  state <= emp_pkg::EMP_STROBE;
               end
               else
                  cnt <= cnt - 4'h1;
            end
            emp_pkg::EMP_STROBE:
            begin
               if (cnt == 4'h0)
               begin
                  // Sample read data in the last strobe cycle, before the edge rises.
                  if (!mv_we)
                     mv_rdata_o <= ext_din;
                  wr_n <= 1'b1;
                  rd_n <= 1'b1;
                  ext_doe <= 1'b0;
                  if (addr_hold_field != 2'h0)
                  begin
                     cnt <= {2'h0, addr_hold_field} - 4'h1;
                     state <= emp_pkg::EMP_HOLD;
                  end
                  else
                  begin
                     claim <= 1'b0;
                     addr_hi_oe <= 1'b0;
                     addr_lo_oe <= 1'b0;
                     mv_done_o <= 1'b1;
                     state <= emp_pkg::EMP_DONE;
                  end
               end
               else
                  cnt <= cnt - 4'h1;
            end
            emp_pkg::EMP_HOLD:
            begin
               if (cnt == 4'h0)
               begin
                  claim <= 1'b0;
                  addr_hi_oe <= 1'b0;
                  addr_lo_oe <= 1'b0;
                  mv_done_o <= 1'b1;
                  state <= emp_pkg::EMP_DONE;
               end
               else
                  cnt <= cnt - 4'h1;
            end
            emp_pkg::EMP_DONE:
            begin
               // One spare cycle lets the core drop its request before idle looks again.
               state <= emp_pkg::EMP_IDLE;
            end
            default:
            begin
               state <= emp_pkg::EMP_IDLE;
            end
         endcase
      end
   end

   // The core stalls from request until the cycle in which done is raised; busy is already low in that cycle.
   assign mv_busy_o = mv_req_i & ~mv_done_o;

   // Steer the pin bundle to the selected group; the other group's enables stay off, though lo_wr_n_o, lo_rd_n_o and lo_ale_o follow every move.
   wire lo_own = claim & ~upper_port_select;
   wire hi_own = claim & upper_port_select;

   assign lo_claim_o = lo_own;
   assign lo_addr_o = ext_addr;
   assign lo_addr_hi_oe_o = lo_own & addr_hi_oe;
   assign lo_addr_lo_oe_o = lo_own & addr_lo_oe;
   assign lo_data_o = ext_dout;
   assign lo_data_oe_o = lo_own & ext_doe;
   assign lo_wr_n_o = wr_n;
   assign lo_rd_n_o = rd_n;
   assign lo_ale_o = ale;

   assign hi_claim_o = hi_own;
   assign hi_addr_o = ext_addr;
   assign hi_addr_hi_oe_o = hi_own & addr_hi_oe;
   assign hi_addr_lo_oe_o = hi_own & addr_lo_oe;
   assign hi_data_o = ext_dout;
   assign hi_data_oe_o = hi_own & ext_doe;

   // Port four: strobes override the top three latch bits only while claimed upper.
   wire [7:0] p4_value = hi_own ? {wr_n, rd_n, ale, port4_data_latch[4:0]} :
      port4_data_latch;

   // Drive mode always follows the mode register, whoever supplies the level.
   genvar p;
   generate
      for (p = 0; p < 8; p = p + 1)
      begin : g_p4
         assign port4_o[p] = p4_value[p];
         assign port4_oe_o[p] = port4_output_mode[p] | ~p4_value[p];
      end
   endgenerate

endmodule // emp_top
`default_nettype wire

// ---- testbench/emp_mem_model.sv ----
// Off-chip byte memory that answers whichever port group is claimed.
`default_nettype none
module emp_mem_model (
   // Clock.
   input wire logic clk_i,
   // Pin levels on the board.
   input wire logic lo_claim_i,
   input wire logic hi_claim_i,
   input wire logic [15:0] lo_addr_i,
   input wire logic [15:0] hi_addr_i,
   input wire logic [7:0] lo_data_i,
   input wire logic [7:0] hi_data_i,
   input wire logic lo_wr_n_i,
   input wire logic lo_rd_n_i,
   input wire logic hi_wr_n_i,
   input wire logic hi_rd_n_i,
   // Read data and the address seen at the last strobe.
   output logic [7:0] q_o,
   output logic [15:0] last_addr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:255];
   logic [7:0] prev_q = 8'h00;
   wire [15:0] addr = hi_claim_i ? hi_addr_i : lo_addr_i;
   wire [7:0] wd = hi_claim_i ? hi_data_i : lo_data_i;
   wire wr = (hi_claim_i & ~hi_wr_n_i) | (lo_claim_i & ~lo_wr_n_i);
   wire rd = (hi_claim_i & ~hi_rd_n_i) | (lo_claim_i & ~lo_rd_n_i);
   // An idle bus shows the inverse of its last value, so stale data looks invalid.
   assign q_o = rd ? mem[addr[7:0]] : ~prev_q;
   // Writes land on every strobe-low edge; the last one wins.
   always @(posedge clk_i)
   begin
      prev_q <= q_o;
      if (wr)
         mem[addr[7:0]] <= wd;
      if (wr | rd)
         last_addr_o <= addr;
   end
endmodule // emp_mem_model
`default_nettype wire

// ---- testbench/emp_top_bench.sv ----
// Self-checking bench for the external memory port.
`include "emp_cfg.svh"
`default_nettype none
module emp_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // Driven inputs.
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0, mwe = 1'b0, msh = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [15:0] maddr = 16'h0;
   logic [7:0] mwd = 8'h00, ext_low = 8'h00, rv, t;
   // Observed outputs; ext_low pulls port four pins down.
   wire [31:0] rdat;
   wire ack, busy, done, lo_clm, hi_clm, lo_wr_n, lo_rd_n;
   wire [7:0] mrd, lo_dq, hi_dq, mem_q, p4_o, p4_oe;
   wire [15:0] lo_a, hi_a, last_a;
   wire [7:0] p4_pin = (p4_o | ~p4_oe) & ~ext_low;
   int err_count = 0, checked = 0, lat, n;
   logic lo_seen, hi_seen, p4_seen;
   logic [7:0] ridx [5] = '{`EMP_IDX_P4_MODE, `EMP_IDX_TIMING, `EMP_IDX_PAGE, `EMP_IDX_CONFIG,
      `EMP_IDX_P4_DATA};
   logic [7:0] rrst [5] = '{`EMP_RST_P4_MODE, `EMP_RST_TIMING, `EMP_RST_PAGE, `EMP_RST_CONFIG,
      `EMP_RST_P4_DATA};
   logic [7:0] tcs [4] = '{8'h0c, 8'hff, 8'h52, 8'h80};
   always #2 clk = ~clk;
   emp_top dut (.clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .mv_req_i(req), .mv_we_i(mwe), .mv_short_i(msh), .mv_addr_i(maddr), .mv_wdata_i(mwd),
      .mv_busy_o(busy), .mv_done_o(done), .mv_rdata_o(mrd), .lo_claim_o(lo_clm),
      .lo_addr_o(lo_a), .lo_addr_hi_oe_o(), .lo_addr_lo_oe_o(), .lo_data_o(lo_dq),
      .lo_data_oe_o(), .lo_data_i(mem_q), .lo_wr_n_o(lo_wr_n), .lo_rd_n_o(lo_rd_n),
      .lo_ale_o(), .hi_claim_o(hi_clm), .hi_addr_o(hi_a), .hi_addr_hi_oe_o(),
      .hi_addr_lo_oe_o(), .hi_data_o(hi_dq), .hi_data_oe_o(), .hi_data_i(mem_q),
      .port4_o(p4_o), .port4_oe_o(p4_oe), .port4_i(p4_pin));
   emp_mem_model mem (.clk_i(clk), .lo_claim_i(lo_clm), .hi_claim_i(hi_clm), .lo_addr_i(lo_a),
      .hi_addr_i(hi_a), .lo_data_i(lo_dq), .hi_data_i(hi_dq), .lo_wr_n_i(lo_wr_n),
      .lo_rd_n_i(lo_rd_n), .hi_wr_n_i(p4_pin[7]), .hi_rd_n_i(p4_pin[6]), .q_o(mem_q),
      .last_addr_o(last_a));
   // Compare and count.
   task automatic check(input string what, input logic [15:0] exp, got);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One classic Wishbone cycle; read data is taken at the ack edge.
   task automatic wb(input logic w, input logic [7:0] idx, d);
      @(posedge clk);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, idx, 2'b00, 4'h1, 24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      rv = rdat[7:0];
      {cyc, stb} <= 2'b00;
   endtask
   // One move; lat counts edges from the raise to the edge that sees done.
   task automatic mv(input logic w, s, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      {req, mwe, msh, maddr, mwd} <= {1'b1, w, s, a, d};
      {lat, lo_seen, hi_seen, p4_seen} = 0;
      do
      begin
         @(posedge clk);
         lat++;
         lo_seen |= lo_clm;
         hi_seen |= hi_clm;
         p4_seen |= hi_clm & ~p4_pin[7];
      end while (done !== 1'b1);
      rv = mrd;
      req <= 1'b0;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      // Reset values, an ignored unmapped index, then read-back of every register.
      for (int i = 0; i < 5; i++)
      begin
         wb(1'b0, ridx[i], 8'h00);
         check("reset value", rrst[i], rv);
      end
      wb(1'b1, 8'h10, 8'h77);
      wb(1'b0, 8'h10, 8'h00);
      check("unmapped", 16'h0, rv);
      for (int i = 0; i < 5; i++)
         wb(1'b1, ridx[i], 8'h5a);
      for (int i = 0; i < 5; i++)
      begin
         wb(1'b0, ridx[i], 8'h00);
         check("read back", 16'h5a, rv);
      end
      wb(1'b1, `EMP_IDX_P4_MODE, 8'hff);
      wb(1'b1, `EMP_IDX_P4_DATA, 8'hff);
      wb(1'b1, `EMP_IDX_TIMING, 8'h10);
      // Every memory mode with an address above on-chip memory.
      for (int m = 0; m < 4; m++)
      begin
         wb(1'b1, `EMP_IDX_CONFIG, 8'(m));
         mv(1'b1, 1'b0, 16'h2345, 8'(m));
         check("claim", {15'h0, m != 0}, {15'h0, lo_seen});
         check("latency", (m != 0) ? 16'd7 : 16'd2, 16'(lat));
      end
      mv(1'b0, 1'b0, 16'h2345, 8'h00);
      check("read data", 16'h03, rv);
      // Timing corners; reads need a strobe that outlasts the pin synchroniser.
      foreach (tcs[i])
      begin
         t = tcs[i];
         n = t[7:6] + t[5:2] + t[1:0] + 3;
         wb(1'b1, `EMP_IDX_TIMING, t);
         mv(1'b1, 1'b0, {8'h10, t}, ~t);
         check("write time", 16'(n), 16'(lat));
         if (t[5:2] >= 4)
         begin
            mv(1'b0, 1'b0, {8'h10, t}, 8'h00);
            check("read time", 16'(n), 16'(lat));
            check("timed read", {8'h00, ~t}, rv);
         end
      end
      wb(1'b1, `EMP_IDX_PAGE, 8'ha5);
      mv(1'b1, 1'b1, 16'h0033, 8'h66);
      check("page addr", 16'ha533, last_a);
      // Upper group with strobes on port four.
      wb(1'b1, `EMP_IDX_TIMING, 8'h10);
      wb(1'b1, `EMP_IDX_CONFIG, 8'h23);
      mv(1'b1, 1'b0, 16'h0077, 8'h99);
      check("groups", 16'h5, {13'h0, hi_seen, lo_seen, p4_seen});
      mv(1'b0, 1'b0, 16'h0077, 8'h00);
      check("upper read", 16'h99, rv);
      check("mode kept", 16'hff, p4_oe);
      // Port four drive, output mode and pin read-back under an outside pull-down.
      wb(1'b1, `EMP_IDX_CONFIG, 8'h00);
      wb(1'b1, `EMP_IDX_P4_MODE, 8'h0f);
      wb(1'b1, `EMP_IDX_P4_DATA, 8'h5a);
      check("p4 level", 16'h5a, p4_o);
      check("p4 enable", 16'haf, p4_oe);
      ext_low <= 8'h03;
      repeat (4) @(posedge clk);
      wb(1'b0, `EMP_IDX_P4_DATA, 8'h00);
      check("p4 pins", 16'h58, rv);
      close_out();
   end
   // Watchdog, far past the few hundred cycles the tests need.
   initial
   begin
      repeat (6000) @(posedge clk);
      err_count++;
      close_out();
   end
endmodule // emp_top_bench
`default_nettype wire

// ---- testbench/emp_top_props.sv ----
// Concurrent checks on the external memory port bus and lower-group pins.
`include "emp_cfg.svh"
`default_nettype none
module emp_top_chk (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Bus and move port.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic mv_req_i,
   input wire logic mv_short_i,
   input wire logic mv_busy_o,
   input wire logic mv_done_o,
   // Pins.
   input wire logic lo_claim_o,
   input wire logic hi_claim_o,
   input wire logic [15:0] lo_addr_o,
   input wire logic lo_addr_hi_oe_o,
   input wire logic lo_data_oe_o,
   input wire logic lo_wr_n_o,
   input wire logic lo_rd_n_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Shadow timing and page bytes at the write edge.
   logic [7:0] tc, pg;
   logic strb_q, clm_q, lo_mv;
   logic [4:0] low_len;
   logic [3:0] since_clm_q, since_rise_q;
   wire wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
   wire strb = lo_wr_n_o & lo_rd_n_o;
   wire strb_fell = ~strb & strb_q;
   wire strb_rose = strb & ~strb_q;
   wire [3:0] since_clm = (lo_claim_o & ~clm_q) ? 4'h0 : since_clm_q + 4'h1;
   wire [3:0] since_rise = strb_rose ? 4'h0 : since_rise_q + 4'h1;
   // Counters watch pins only, never the sequencer state.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tc <= `EMP_RST_TIMING;
         pg <= `EMP_RST_PAGE;
         {strb_q, clm_q, lo_mv, low_len, since_clm_q, since_rise_q} <= {3'h4, 13'h0};
      end
      else
      begin
         if (wr_take && wb_adr_i[9:2] == `EMP_IDX_TIMING)
            tc <= wb_dat_i[7:0];
         if (wr_take && wb_adr_i[9:2] == `EMP_IDX_PAGE)
            pg <= wb_dat_i[7:0];
         {strb_q, clm_q, since_clm_q, since_rise_q} <= {strb, lo_claim_o, since_clm, since_rise};
         lo_mv <= lo_claim_o | (lo_mv & ~mv_done_o);
         low_len <= strb ? 5'h00 : low_len + 5'h01;
      end
   end
   // Strobe edges of a lower-group move, without multiplexing.
   sequence s_strobe_start;
      lo_claim_o && strb_fell;
   endsequence
   sequence s_strobe_end;
      strb_rose && clm_q;
   endsequence
   a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single pulse");
   a_one_group: assert property (!(lo_claim_o && hi_claim_o))
      else $error("both groups claimed");
   a_claim_in_move: assert property (lo_claim_o || hi_claim_o |-> mv_req_i)
      else $error("claim outside a move");
   a_read_released: assert property (lo_claim_o && !lo_rd_n_o |-> !lo_data_oe_o)
      else $error("data driven during read");
   a_page_high: assert property (lo_claim_o && mv_short_i && lo_addr_hi_oe_o |->
      lo_addr_o[15:8] == pg) else $error("high address not page byte");
   a_setup_count: assert property (s_strobe_start |-> since_clm == {2'h0, tc[7:6]})
      else $error("setup length wrong");
   a_width_count: assert property (s_strobe_end |-> low_len == {1'b0, tc[5:2]} + 5'h01)
      else $error("strobe width wrong");
   a_hold_count: assert property (mv_done_o && lo_mv |-> since_rise == {2'h0, tc[1:0]})
      else $error("hold length wrong");
   a_stall_busy: assert property (lo_claim_o || hi_claim_o |-> mv_busy_o)
      else $error("core not stalled in a move");
endmodule // emp_top_chk
bind emp_top emp_top_chk chk (.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_ack_o, .mv_req_i, .mv_short_i, .mv_busy_o, .mv_done_o, .lo_claim_o,
   .hi_claim_o, .lo_addr_o, .lo_addr_hi_oe_o, .lo_data_oe_o, .lo_wr_n_o, .lo_rd_n_o);
`default_nettype wire
